// File: hdl/spz_pkg.sv
package spz_pkg;
  // register map
  localparam int          SPZ_ADDR_W         = 8;
  localparam logic [7:0]  SPZ_CTRL_ADDR      = 8'h98;
  localparam logic [7:0]  SPZ_DATA_ADDR      = 8'h99;
  localparam logic [7:0]  SPZ_CFG_ADDR       = 8'h9c;
  localparam logic [7:0]  SPZ_INT_STAT_ADDR  = 8'h9d;
  localparam logic [7:0]  SPZ_INT_CLR_ADDR   = 8'h9e;
  localparam logic [7:0]  SPZ_INT_EN_ADDR    = 8'h9f;
  // serial_control_status, config and interrupt register fields
  localparam int          SPZ_MODE_HI_BIT    = 7;
  localparam int          SPZ_MODE_MID_BIT   = 6;
  localparam int          SPZ_MP_BIT         = 5;
  localparam int          SPZ_REN_BIT        = 4;
  localparam int          SPZ_TB8_BIT        = 3;
  localparam int          SPZ_RB8_BIT        = 2;
  localparam int          SPZ_TI_BIT         = 1;
  localparam int          SPZ_RI_BIT         = 0;
  localparam int          SPZ_RATE_DOUBLING_CONTROL_BIT       = 0;
  localparam int          SPZ_INT_RX_BIT     = 0;
  localparam int          SPZ_INT_TX_BIT     = 1;
  // reset values
  localparam logic [7:0]  SPZ_CTRL_RESET     = 8'h00;
  localparam logic [7:0]  SPZ_DATA_RESET     = 8'h00;
  localparam logic        SPZ_CFG_RESET      = 1'b0;
  localparam logic [1:0]  SPZ_INT_RESET      = 2'h0;
  // bit times in peripheral clock periods
  localparam int          SPZ_SYNC_SLOW_PCLK = 12;
  localparam int          SPZ_SYNC_FAST_PCLK = 4;
  localparam int          SPZ_FIX_SLOW_PCLK  = 64;
  localparam int          SPZ_FIX_FAST_PCLK  = 32;
  localparam int          SPZ_OVERSAMPLE     = 16;
  localparam logic [5:0]  SPZ_SYNC_SLOW_CNT  = 6'(SPZ_SYNC_SLOW_PCLK);
  localparam logic [5:0]  SPZ_SYNC_FAST_CNT  = 6'(SPZ_SYNC_FAST_PCLK);
  localparam logic [2:0]  SPZ_FIX_SLOW_DIV   = 3'(SPZ_FIX_SLOW_PCLK / SPZ_OVERSAMPLE);
  localparam logic [2:0]  SPZ_FIX_FAST_DIV   = 3'(SPZ_FIX_FAST_PCLK / SPZ_OVERSAMPLE);
  // timer overflows per oversample tick, normal and doubled rate
  localparam logic [2:0]  SPZ_TMR_DIV_NORMAL = 3'h2;
  localparam logic [2:0]  SPZ_TMR_DIV_DOUBLE = 3'h1;
  localparam logic [3:0]  SPZ_OS_LAST        = 4'(SPZ_OVERSAMPLE - 1);
  localparam logic [3:0]  SPZ_OS_HALF        = 4'(SPZ_OVERSAMPLE / 2 - 1);

  typedef enum logic [1:0] {
    SPZ_RX_IDLE  = 2'b00,
    SPZ_RX_START = 2'b01,
    SPZ_RX_DATA  = 2'b11,
    SPZ_RX_STOP  = 2'b10
  } spz_rx_state_t;

  typedef enum logic [1:0] {
    SPZ_TX_IDLE  = 2'b00,
    SPZ_TX_ASYNC = 2'b01,
    SPZ_TX_SYNC  = 2'b11
  } spz_tx_state_t;
endpackage : spz_pkg

// File: hdl/spz_serial_port.sv
`timescale 1ns/1ps
// What this block does
// R1: async frames carry one start, one stop bit
// R2: two select bits choose sync, 10-bit, 11-bit
// R3: sync bit lasts 12 or 4 clocks
// R4: fixed 11-bit mode: 64 or 32 clocks
// R5: other async modes use timer overflow rate
// R6: 10-bit multiprocessor: complete only on valid stop
// R7: 11-bit multiprocessor: ignore frames with ninth zero
// R8: receive enable gates reception, starts sync receive
// R9: ninth transmit bit sent in 11-bit modes
// R10: ninth received bit or stop bit captured
// R11: transmit complete after last data bit
// R12: receive complete after last bit sample
// R13: one data address: write transmit, read receive
// R14: rate doubling doubles the async bit rate
// R15: data buffer write starts transmission
// R16: receive buffer loads with receive complete
module spz_serial_port
  import spz_pkg::*;
(
  // clock and reset
  input  wire logic                  clk_sys,
  input  wire logic                  reset_n,
  // register port
  input  wire logic [SPZ_ADDR_W-1:0] reg_addr,
  input  wire logic [7:0]            reg_wdata,
  input  wire logic                  reg_wr,
  input  wire logic                  reg_rd,
  output logic      [7:0]            reg_rdata,
  // system side
  input  wire logic                  baud_overflow,
  input  wire logic                  idle_mode,
  output logic                       irq,
  // serial pins
  input  wire logic                  rxd_in,
  output logic                       rxd_out,
  output logic                       rxd_oe,
  output logic                       txd
);
  import spz_pkg::*;

  logic [7:0]    ctrl_reg, ctrl_next;
  logic [7:0]    tx_buf_reg;
  logic [7:0]    rx_buf_reg, rx_buf_next;
  logic          cfg_reg;
  logic [1:0]    int_stat_reg, int_stat_next;
  logic [1:0]    int_en_reg;
  logic [7:0]    rdata_reg;
  logic          irq_reg;
  logic          rxd_meta_reg, rxd_sync_reg;
  logic [2:0]    os_cnt_reg;
  spz_rx_state_t rx_state_reg, rx_state_next;
  logic [3:0]    rx_tick_reg, rx_tick_next;
  logic [3:0]    rx_bit_reg, rx_bit_next;
  logic [8:0]    rx_shift_reg, rx_shift_next;
  spz_tx_state_t tx_state_reg, tx_state_next;
  logic [5:0]    tx_cnt_reg, tx_cnt_next;
  logic [3:0]    tx_bit_reg, tx_bit_next;
  logic [10:0]   tx_shift_reg, tx_shift_next;
  logic          sync_rx_reg, sync_rx_next;
  logic          txd_reg, txd_next;
  logic          rxd_out_reg, rxd_out_next;
  logic          rxd_oe_reg, rxd_oe_next;
  logic          ti_set, sync_done, async_ri;
  logic [7:0]    sync_rx_data;

  // register decode
  wire wr_ctrl = reg_wr && (reg_addr == SPZ_CTRL_ADDR);
  wire wr_data = reg_wr && (reg_addr == SPZ_DATA_ADDR);
  wire wr_cfg  = reg_wr && (reg_addr == SPZ_CFG_ADDR);
  wire wr_clr  = reg_wr && (reg_addr == SPZ_INT_CLR_ADDR);
  wire wr_en   = reg_wr && (reg_addr == SPZ_INT_EN_ADDR);

  // mode decode
  wire mode_hi     = ctrl_reg[SPZ_MODE_HI_BIT];
  wire mode_mid    = ctrl_reg[SPZ_MODE_MID_BIT];
  wire mp_sel      = ctrl_reg[SPZ_MP_BIT];
  wire rx_enable   = ctrl_reg[SPZ_REN_BIT];
  wire mode_sync   = !mode_hi && !mode_mid;                 // R2
  wire mode_ten    = !mode_hi && mode_mid;                  // R2
  wire mode_eleven = mode_hi;                               // R2
  wire mode_fixed  = mode_hi && !mode_mid;
  wire pclk_run    = !idle_mode;

  // oversample tick, sixteen per async bit
  wire       tick_src   = mode_fixed ? pclk_run : (baud_overflow && pclk_run); // R5
  wire [2:0] fix_div    = cfg_reg ? SPZ_FIX_FAST_DIV : SPZ_FIX_SLOW_DIV;      // R4
  wire [2:0] tmr_div    = cfg_reg ? SPZ_TMR_DIV_DOUBLE : SPZ_TMR_DIV_NORMAL;  // R14
  wire [2:0] tick_limit = mode_fixed ? fix_div : tmr_div;
  wire       tick_os    = tick_src && (os_cnt_reg >= tick_limit - 3'h1);
  // a new transmit restarts the prescaler so its start bit gets the full length;
  // a reception running at that moment may slip by at most one oversample tick
  wire       tx_start    = wr_data && (tx_state_reg == SPZ_TX_IDLE);
  wire [2:0] os_cnt_next = tx_start ? 3'h0 :
                           (!tick_src ? os_cnt_reg : (tick_os ? 3'h0 : os_cnt_reg + 3'h1));

  // async receive
  wire [3:0] rx_bits     = mode_eleven ? 4'h9 : 4'h8;
  wire       rx_at_mid   = tick_os && (rx_tick_reg == SPZ_OS_LAST);
  wire [8:0] rx_shift_in = {rxd_sync_reg, rx_shift_reg[8:1]};
  wire       rx_last_bit = (rx_state_reg == SPZ_RX_DATA) && rx_at_mid
                           && (rx_bit_reg == rx_bits - 4'h1);
  wire       rx_stop_smp = (rx_state_reg == SPZ_RX_STOP) && rx_at_mid;
  wire       acc_eleven  = rx_last_bit && mode_eleven && (!mp_sel || rxd_sync_reg); // R7
  wire       acc_ten     = rx_stop_smp && mode_ten && (!mp_sel || rxd_sync_reg);    // R6

  always_comb begin
    rx_state_next = rx_state_reg;
    rx_tick_next  = rx_tick_reg;
    rx_bit_next   = rx_bit_reg;
    rx_shift_next = rx_shift_reg;
    case (rx_state_reg)
      SPZ_RX_IDLE: begin
        if (!mode_sync && rx_enable && !rxd_sync_reg) begin // R8
          rx_state_next = SPZ_RX_START;
          rx_tick_next  = 4'h0;
        end
      end
      SPZ_RX_START: begin
        if (tick_os) begin
          rx_tick_next = rx_tick_reg + 4'h1;
          if (rx_tick_reg == SPZ_OS_HALF) begin
            // a start bit that is gone at mid-bit was a glitch
            rx_state_next = rxd_sync_reg ? SPZ_RX_IDLE : SPZ_RX_DATA; // R1
            rx_tick_next  = 4'h0;
            rx_bit_next   = 4'h0;
          end
        end
      end
      SPZ_RX_DATA: begin
        if (tick_os) begin
          rx_tick_next = rx_tick_reg + 4'h1;
          if (rx_at_mid) begin
            rx_shift_next = rx_shift_in;
            rx_bit_next   = rx_bit_reg + 4'h1;
            if (rx_last_bit) begin
              rx_state_next = SPZ_RX_STOP;
            end
          end
        end
      end
      SPZ_RX_STOP: begin
        if (tick_os) begin
          rx_tick_next = rx_tick_reg + 4'h1;
          if (rx_at_mid) begin
            rx_state_next = SPZ_RX_IDLE; // R1
          end
        end
      end
      default: rx_state_next = SPZ_RX_IDLE;
    endcase
    if (!rx_enable || mode_sync) begin
      rx_state_next = SPZ_RX_IDLE; // R8
    end
  end

  // transmit and synchronous engine
  wire [3:0]  tx_bits     = mode_eleven ? 4'hb : 4'ha;
  wire        tx_ninth    = mode_eleven ? ctrl_reg[SPZ_TB8_BIT] : 1'b1; // R9
  wire [10:0] tx_frame    = {1'b1, tx_ninth, reg_wdata, 1'b0};          // R1
  wire [5:0]  sync_period = mp_sel ? SPZ_SYNC_FAST_CNT : SPZ_SYNC_SLOW_CNT; // R3
  wire        sync_end    = pclk_run && (tx_cnt_reg == sync_period - 6'h1);
  wire        sync_rx_go  = mode_sync && rx_enable && !ctrl_reg[SPZ_RI_BIT]; // R8

  always_comb begin
    tx_state_next = tx_state_reg;
    tx_cnt_next   = tx_cnt_reg;
    tx_bit_next   = tx_bit_reg;
    tx_shift_next = tx_shift_reg;
    sync_rx_next  = sync_rx_reg;
    ti_set        = 1'b0;
    sync_done     = 1'b0;
    sync_rx_data  = {rxd_sync_reg, tx_shift_reg[7:1]};
    case (tx_state_reg)
      SPZ_TX_IDLE: begin
        tx_cnt_next = 6'h0;
        tx_bit_next = 4'h0;
        if (wr_data) begin // R15
          tx_state_next = mode_sync ? SPZ_TX_SYNC : SPZ_TX_ASYNC;
          tx_shift_next = mode_sync ? {3'h0, reg_wdata} : tx_frame;
          sync_rx_next  = 1'b0;
        end else if (sync_rx_go) begin
          tx_state_next = SPZ_TX_SYNC;
          sync_rx_next  = 1'b1;
        end
      end
      SPZ_TX_ASYNC: begin
        if (tick_os) begin
          tx_cnt_next = 6'(tx_cnt_reg[3:0] + 4'h1);
          if (tx_cnt_reg[3:0] == SPZ_OS_LAST) begin
            tx_cnt_next   = 6'h0;
            tx_shift_next = {1'b1, tx_shift_reg[10:1]};
            tx_bit_next   = tx_bit_reg + 4'h1;
            ti_set        = (tx_bit_reg == tx_bits - 4'h2); // R11
            if (tx_bit_reg == tx_bits - 4'h1) begin
              tx_state_next = SPZ_TX_IDLE;
            end
          end
        end
      end
      SPZ_TX_SYNC: begin
        if (pclk_run) begin
          tx_cnt_next = tx_cnt_reg + 6'h1;
        end
        if (sync_end) begin
          tx_cnt_next   = 6'h0;
          tx_bit_next   = tx_bit_reg + 4'h1;
          tx_shift_next = sync_rx_reg ? {3'h0, sync_rx_data}
                                      : {1'b0, tx_shift_reg[10:1]};
          if (tx_bit_reg == 4'h7) begin
            tx_state_next = SPZ_TX_IDLE;
            sync_done     = 1'b1;
            ti_set        = !sync_rx_reg; // R11
          end
        end
      end
      default: tx_state_next = SPZ_TX_IDLE;
    endcase
  end

  // pin drive: sync clock low in the first half of each bit
  wire sync_clk_low = tx_cnt_reg < (sync_period >> 1);
  always_comb begin
    txd_next     = 1'b1;
    rxd_out_next = 1'b1;
    rxd_oe_next  = 1'b0;
    if (tx_state_next == SPZ_TX_ASYNC) begin
      txd_next = tx_shift_next[0];
    end else if (tx_state_next == SPZ_TX_SYNC) begin
      txd_next     = !((tx_cnt_next < (sync_period >> 1)) && (tx_state_reg == SPZ_TX_SYNC));
      rxd_out_next = tx_shift_next[0];
      rxd_oe_next  = !sync_rx_next;
    end
  end

  // receive completion and status update
  wire sync_ri = sync_done && sync_rx_reg;                  // R12
  assign async_ri = acc_eleven || acc_ten;                  // R12
  wire ri_set = sync_ri || async_ri;

  always_comb begin
    ctrl_next   = wr_ctrl ? reg_wdata : ctrl_reg;
    rx_buf_next = rx_buf_reg;
    if (sync_ri) begin
      rx_buf_next = sync_rx_data; // R16
    end else if (acc_eleven) begin
      rx_buf_next           = rx_shift_in[7:0];        // R16
      ctrl_next[SPZ_RB8_BIT] = rx_shift_in[8];         // R10
    end else if (acc_ten) begin
      rx_buf_next           = rx_shift_reg[8:1];       // R16
      ctrl_next[SPZ_RB8_BIT] = rxd_sync_reg;           // R10
    end
    // hardware set wins over a software clear in the same cycle
    ctrl_next[SPZ_TI_BIT] = ctrl_next[SPZ_TI_BIT] | ti_set; // R11
    ctrl_next[SPZ_RI_BIT] = ctrl_next[SPZ_RI_BIT] | ri_set; // R12
  end

  wire [1:0] int_events = {ti_set, ri_set};
  wire [1:0] int_clear  = wr_clr ? reg_wdata[1:0] : 2'h0;
  assign int_stat_next = (int_stat_reg & ~int_clear) | int_events;
  wire irq_next = |(int_stat_next & (wr_en ? reg_wdata[1:0] : int_en_reg));

  // read mux, data address returns the receive buffer only
  wire [7:0] rd_mux =
    (reg_addr == SPZ_CTRL_ADDR)     ? ctrl_reg :
    (reg_addr == SPZ_DATA_ADDR)     ? rx_buf_reg :            // R13
    (reg_addr == SPZ_CFG_ADDR)      ? {7'h0, cfg_reg} :
    (reg_addr == SPZ_INT_STAT_ADDR) ? {6'h0, int_stat_reg} :
    (reg_addr == SPZ_INT_EN_ADDR)   ? {6'h0, int_en_reg} : 8'h00;

  always_ff @(posedge clk_sys) begin
    if (!reset_n) begin
      ctrl_reg     <= SPZ_CTRL_RESET;
      tx_buf_reg   <= SPZ_DATA_RESET;
      rx_buf_reg   <= SPZ_DATA_RESET;
      cfg_reg      <= SPZ_CFG_RESET;
      int_stat_reg <= SPZ_INT_RESET;
      int_en_reg   <= SPZ_INT_RESET;
      rdata_reg    <= 8'h00;
      irq_reg      <= 1'b0;
    end else begin
      ctrl_reg     <= ctrl_next;
      tx_buf_reg   <= wr_data ? reg_wdata : tx_buf_reg; // R13
      rx_buf_reg   <= rx_buf_next;
      cfg_reg      <= wr_cfg ? reg_wdata[SPZ_RATE_DOUBLING_CONTROL_BIT] : cfg_reg;
      int_stat_reg <= int_stat_next;
      int_en_reg   <= wr_en ? reg_wdata[1:0] : int_en_reg;
      rdata_reg    <= reg_rd ? rd_mux : 8'h00;
      irq_reg      <= irq_next;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!reset_n) begin
      rxd_meta_reg <= 1'b1;
      rxd_sync_reg <= 1'b1;
      os_cnt_reg   <= 3'h0;
    end else begin
      rxd_meta_reg <= rxd_in;
      rxd_sync_reg <= rxd_meta_reg;
      os_cnt_reg   <= os_cnt_next;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!reset_n) begin
      rx_state_reg <= SPZ_RX_IDLE;
      rx_tick_reg  <= 4'h0;
      rx_bit_reg   <= 4'h0;
      rx_shift_reg <= 9'h000;
    end else begin
      rx_state_reg <= rx_state_next;
      rx_tick_reg  <= rx_tick_next;
      rx_bit_reg   <= rx_bit_next;
      rx_shift_reg <= rx_shift_next;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!reset_n) begin
      tx_state_reg <= SPZ_TX_IDLE;
      tx_cnt_reg   <= 6'h0;
      tx_bit_reg   <= 4'h0;
      tx_shift_reg <= 11'h7ff;
      sync_rx_reg  <= 1'b0;
      txd_reg      <= 1'b1;
      rxd_out_reg  <= 1'b1;
      rxd_oe_reg   <= 1'b0;
    end else begin
      tx_state_reg <= tx_state_next;
      tx_cnt_reg   <= tx_cnt_next;
      tx_bit_reg   <= tx_bit_next;
      tx_shift_reg <= tx_shift_next;
      sync_rx_reg  <= sync_rx_next;
      txd_reg      <= txd_next;
      rxd_out_reg  <= rxd_out_next;
      rxd_oe_reg   <= rxd_oe_next;
    end
  end

  wire unused_ok = sync_clk_low ^ (|tx_buf_reg);

  assign reg_rdata = rdata_reg;
  assign irq       = irq_reg;
  assign txd       = txd_reg;
  assign rxd_out   = rxd_out_reg;
  assign rxd_oe    = rxd_oe_reg;
endmodule : spz_serial_port

// File: verification/spz_remote_node.sv
`timescale 1ns/1ps
module spz_remote_node (
  // clock
  input  wire logic clk_sys,
  // serial line
  input  wire logic txd,
  output logic      line
);
  // the line idles at the mark level
  initial line = 1'b1;

  task automatic send(input logic [10:0] f, input int n, input int bt);
    @(posedge clk_sys);
    for (int i = 0; i < n; i++) begin
      line <= f[i];
      repeat (bt) @(posedge clk_sys);
    end
    line <= 1'b1;
    repeat (bt) @(posedge clk_sys);
  endtask : send

  // samples each bit in its middle; bits above n read as 1
  task automatic grab(input int n, input int bt, output logic [10:0] f);
    f = 11'h7ff;
    @(negedge txd);
    repeat (bt / 2) @(negedge clk_sys);
    for (int i = 0; i < n; i++) begin
      f[i] = txd;
      repeat (bt) @(negedge clk_sys);
    end
  endtask : grab

  // synchronous partner: a new bit at each falling shift clock, mark level after
  task automatic shift_out(input logic [7:0] d);
    for (int i = 0; i < 8; i++) begin
      @(negedge txd);
      line <= d[i];
    end
    @(posedge txd);
    repeat (4) @(posedge clk_sys);
    line <= 1'b1;
  endtask : shift_out
endmodule : spz_remote_node

// File: verification/spz_serial_port_asserts.sv
`timescale 1ns/1ps
module spz_serial_port_asserts (
  // clock and reset
  input wire logic                          clk_sys,
  input wire logic                          reset_n,
  // register port
  input wire logic [spz_pkg::SPZ_ADDR_W-1:0] reg_addr,
  input wire logic [7:0]                    reg_wdata,
  input wire logic                          reg_wr,
  input wire logic                          reg_rd,
  input wire logic [7:0]                    reg_rdata,
  // system side
  input wire logic                          baud_overflow,
  input wire logic                          idle_mode,
  input wire logic                          irq,
  // serial pins
  input wire logic                          rxd_in,
  input wire logic                          rxd_out,
  input wire logic                          rxd_oe,
  input wire logic                          txd
);
  import spz_pkg::*;
  logic [7:3] ctrl_h;
  logic       rate_doubling_control_h;
  logic [1:0] en_h;
  logic       tx_wr;
  logic       mapped;
  assign tx_wr  = reg_wr && (reg_addr == SPZ_DATA_ADDR);
  assign mapped = reg_addr inside {8'h98, 8'h99, 8'h9c, 8'h9d, 8'h9e, 8'h9f};

  // shadow of the software-written controls
  always_ff @(posedge clk_sys) begin
    if (!reset_n) begin
      ctrl_h <= 5'h00;
      rate_doubling_control_h <= 1'b0;
      en_h   <= 2'h0;
    end else if (reg_wr) begin
      if (reg_addr == SPZ_CTRL_ADDR) ctrl_h <= reg_wdata[7:3];
      if (reg_addr == SPZ_CFG_ADDR) rate_doubling_control_h <= reg_wdata[0];
      if (reg_addr == SPZ_INT_EN_ADDR) en_h <= reg_wdata[1:0];
    end
  end

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!reset_n);

  sequence s_start64;
    !txd ##63 !txd ##1 txd;
  endsequence
  sequence s_oe12;
    rxd_oe [*8] ##88 rxd_oe ##1 !rxd_oe;
  endsequence

  property p_rdata_idle;
    !$past(reg_rd) |-> reg_rdata == 8'h00;
  endproperty
  a_rdata_idle: assert property (p_rdata_idle)
    else $error("read data outside its slot");
  property p_unmapped;
    reg_rd && !mapped |=> reg_rdata == 8'h00;
  endproperty
  a_unmapped: assert property (p_unmapped)
    else $error("unmapped read not zero");
  property p_reset_out;
    $rose(reset_n) |-> txd && rxd_out && !rxd_oe && !irq;
  endproperty
  a_reset_out: assert property (p_reset_out)
    else $error("outputs not idle after reset");
  property p_irq_mask;
    en_h == 2'h0 && $past(en_h) == 2'h0 |-> !irq;
  endproperty
  a_irq_mask: assert property (p_irq_mask)
    else $error("interrupt while masked");
  property p_fix_bit;
    tx_wr && ctrl_h[7:6] == 2'b10 && !rate_doubling_control_h && reg_wdata[0] |=> s_start64;
  endproperty
  a_fix_bit: assert property (p_fix_bit)
    else $error("fixed mode start bit length wrong");
  property p_ninth;
    tx_wr && ctrl_h[7:6] == 2'b10 && rate_doubling_control_h |=> ##295 txd == ctrl_h[3];
  endproperty
  a_ninth: assert property (p_ninth)
    else $error("ninth bit wrong");
  property p_tx_start;
    tx_wr && ctrl_h[7:6] == 2'b01 |=> !txd;
  endproperty
  a_tx_start: assert property (p_tx_start)
    else $error("start bit missing");
  property p_sync_oe;
    tx_wr && ctrl_h[7:5] == 3'b000 |=> s_oe12;
  endproperty
  a_sync_oe: assert property (p_sync_oe)
    else $error("sync transfer length wrong");
endmodule : spz_serial_port_asserts

bind spz_serial_port spz_serial_port_asserts u_asserts (
  .clk_sys(clk_sys), .reset_n(reset_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
  .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .baud_overflow(baud_overflow),
  .idle_mode(idle_mode), .irq(irq), .rxd_in(rxd_in), .rxd_out(rxd_out), .rxd_oe(rxd_oe),
  .txd(txd)
);

// File: verification/serial_port_zero_usart_bench.sv
`timescale 1ns/1ps
module serial_port_zero_usart_bench;
  logic       clk_sys, reset_n, reg_wr, reg_rd, baud_overflow, idle_mode;
  logic [7:0] reg_addr, reg_wdata, reg_rdata;
  logic       irq, rxd_out, rxd_oe, txd, node_line;
  wire        rxd_in = rxd_oe ? rxd_out : node_line;
  int         bad_count, samples_checked;

  spz_serial_port dut (.clk_sys(clk_sys), .reset_n(reset_n), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .baud_overflow(baud_overflow), .idle_mode(idle_mode), .irq(irq), .rxd_in(rxd_in),
    .rxd_out(rxd_out), .rxd_oe(rxd_oe), .txd(txd));
  spz_remote_node node (.clk_sys(clk_sys), .txd(txd), .line(node_line));

  initial begin
    clk_sys = 1'b0;
    forever #4 clk_sys = ~clk_sys;
  end
  // timer overflow every second cycle: 64 clocks a bit in timer modes, 32 with rate doubling
  always @(posedge clk_sys) baud_overflow <= ~baud_overflow;

  task automatic wrap_up();
    $display("comparisons %0d mismatches %0d", samples_checked, bad_count);
    if (bad_count == 0 && samples_checked > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask : wrap_up

  task automatic chk(input logic [10:0] got, input logic [10:0] exp);
    samples_checked++;
    if (got !== exp) begin
      bad_count++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_sys);
    reg_wr <= 1'b1; reg_addr <= a; reg_wdata <= d;
    @(posedge clk_sys);
    reg_wr <= 1'b0;
  endtask : wr

  task automatic rdc(input logic [7:0] a, input logic [7:0] exp);
    @(posedge clk_sys);
    reg_rd <= 1'b1; reg_addr <= a;
    @(posedge clk_sys);
    reg_rd <= 1'b0;
    @(negedge clk_sys);
    chk({3'h0, reg_rdata}, {3'h0, exp});
  endtask : rdc

  task automatic t_reset_values();
    logic [7:0] addrs [6] = '{8'h98, 8'h99, 8'h9c, 8'h9d, 8'h9f, 8'h97};
    foreach (addrs[i]) rdc(addrs[i], 8'h00);
  endtask : t_reset_values

  task automatic t_fixed_tx(input logic rate_doubling_control, input int bt);
    logic [10:0] f;
    wr(8'h9c, {7'h00, rate_doubling_control});
    wr(8'h9f, 8'h02);
    wr(8'h98, 8'h88);
    fork node.grab(11, bt, f); wr(8'h99, 8'ha5); join
    chk(f, {2'b11, 8'ha5, 1'b0});
    rdc(8'h9d, 8'h02);
    chk({10'h0, irq}, 11'h001);
    wr(8'h9f, 8'h00);
    rdc(8'h98, 8'h8a);
    chk({10'h0, irq}, 11'h000);
    wr(8'h9f, 8'h02);
    wr(8'h9e, 8'h03);
    wr(8'h98, 8'h88);
    rdc(8'h9d, 8'h00);
    chk({10'h0, irq}, 11'h000);
  endtask : t_fixed_tx

  task automatic t_async_rx();
    logic [10:0] f;
    wr(8'h9c, 8'h00);
    wr(8'h98, 8'h40);
    node.send({2'b11, 8'h11, 1'b0}, 10, 64);
    rdc(8'h98, 8'h40);
    wr(8'h98, 8'h50);
    node.send({2'b11, 8'h96, 1'b0}, 10, 64);
    rdc(8'h98, 8'h55);
    rdc(8'h99, 8'h96);
    wr(8'h98, 8'h70);
    node.send({2'b00, 8'h22, 1'b0}, 10, 64);
    rdc(8'h98, 8'h70);
    // the low stop bit may look like a new start: clearing receive enable drops it
    wr(8'h98, 8'h60);
    wr(8'h98, 8'hf0);
    node.send({2'b10, 8'h33, 1'b0}, 11, 64);
    rdc(8'h98, 8'hf0);
    node.send({2'b11, 8'h5a, 1'b0}, 11, 64);
    rdc(8'h98, 8'hf5);
    rdc(8'h99, 8'h5a);
    wr(8'h98, 8'h40);
    fork node.grab(10, 64, f); wr(8'h99, 8'hc3); join
    chk(f, {2'b11, 8'hc3, 1'b0});
    wr(8'h9c, 8'h01);
    fork node.grab(10, 32, f); wr(8'h99, 8'h3e); join
    chk(f, {2'b11, 8'h3e, 1'b0});
  endtask : t_async_rx

  task automatic t_sync_tx();
    logic [7:0] got;
    wr(8'h9e, 8'h03);
    wr(8'h98, 8'h00);
    wr(8'h99, 8'h3c);
    repeat (6) @(posedge clk_sys);
    for (int i = 0; i < 8; i++) begin
      @(negedge clk_sys);
      got[i] = rxd_out;
      repeat (12) @(posedge clk_sys);
    end
    chk({3'h0, got}, {3'h0, 8'h3c});
    repeat (12) @(posedge clk_sys);
    rdc(8'h98, 8'h02);
    rdc(8'h9d, 8'h02);
    rdc(8'h99, 8'h5a);
  endtask : t_sync_tx

  // fast synchronous receive, frozen for a while by idle mode
  task automatic t_sync_rx();
    wr(8'h9e, 8'h03);
    fork
      node.shift_out(8'h6b);
      begin
        wr(8'h98, 8'h30);
        repeat (10) @(posedge clk_sys);
        idle_mode <= 1'b1;
        repeat (30) @(posedge clk_sys);
        rdc(8'h98, 8'h30);
        @(posedge clk_sys);
        idle_mode <= 1'b0;
      end
    join
    rdc(8'h98, 8'h31);
    rdc(8'h99, 8'h6b);
    rdc(8'h9d, 8'h01);
  endtask : t_sync_rx

  initial begin
    reset_n = 1'b0; reg_addr = 8'h00; reg_wdata = 8'h00; reg_wr = 1'b0;
    reg_rd = 1'b0; baud_overflow = 1'b0; idle_mode = 1'b0;
    repeat (12) @(posedge clk_sys);
    reset_n <= 1'b1;
    t_reset_values();
    t_fixed_tx(1'b0, 64);
    t_fixed_tx(1'b1, 32);
    t_async_rx();
    t_sync_tx();
    t_sync_rx();
    wrap_up();
  end

  initial begin
    repeat (30000) @(posedge clk_sys);
    bad_count++;
    wrap_up();
  end
endmodule : serial_port_zero_usart_bench
